// file: verilog/sdl_word_loader.sv
// Serial word loader: input shift register, DAC latch and chain output
//
// Contract
// RQ1 - Shift data in on shift-clock fall during frame
// RQ2 - Host lowers frame sync before data clocks
// RQ3 - Host sends four unused bits first, LSB last
// RQ4 - Strobe low: latch updates on sixteenth fall
// RQ5 - External strobe fall transfers register to latch
// RQ6 - Host holds strobe low at least 50 ns
// RQ7 - Byte hosts keep frame low between bytes
// RQ8 - Serial host uses polarity 0, phase 1
// RQ9 - Chain enable held high on every device
// RQ10 - Data ripples through registers, sixteen clocks each
// RQ11 - Chain shares clock, data and frame lines
// RQ12 - Raise frame, then one shared strobe pulse
// RQ13 - Strobe may come from frame-rise one-shot
// RQ14 - Latch takes only low twelve word bits
// RQ15 - Clear low forces latch to all zeros
// RQ16 - Chain output carries bit leaving MSB end
`timescale 1ns/10ps
module sdl_word_loader (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Serial link pins
  input wire logic shift_clk_i,
  input wire logic serial_in_i,
  input wire logic frame_sync_n_i,
  // Update and control pins
  input wire logic load_strobe_n_i,
  input wire logic chain_enable_i,
  input wire logic clear_n_i,
  // Converter side
  output logic [sdl_pkg::DAC_W-1:0] dac_code_o,
  output logic dac_update_o,
  output logic [sdl_pkg::WORD_W-1:0] input_word_o,
  // Cascade output
  output logic chain_out_o
);
  import sdl_pkg::*;

  // Low bits of a word that reach the converter
  function automatic logic [DAC_W-1:0] dac_bits(input logic [WORD_W-1:0] word);
    dac_bits = word[DAC_W-1:0];
  endfunction : dac_bits

  // Synchronised pins
  sdl_pin_if pins ();

  // Registers
  logic [WORD_W-1:0] shift_ff;    // Input shift register
  logic [CNT_W-1:0] cnt_ff;       // Falling edges seen in this frame
  logic [DAC_W-1:0] dac_ff;       // DAC latch
  logic update_ff;                // Latch loaded last cycle
  logic chain_out_ff;             // Registered cascade bit

  // Decoded controls
  logic shift_en_w;               // Take one bit this cycle
  logic [WORD_W-1:0] nxt_shift_w; // Register after taking that bit
  logic [CNT_W-1:0] nxt_cnt_w;    // Next edge count
  logic auto_w;                   // Automatic update on the sixteenth edge
  logic ext_w;                    // Update from a falling load strobe
  logic [DAC_W-1:0] nxt_dac_w;    // Next latch value
  logic nxt_chain_w;              // Next cascade bit

  // Every pin is brought into the clock domain before use
  sdl_pin_sync u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .shift_clk_i(shift_clk_i),
    .serial_in_i(serial_in_i),
    .frame_sync_n_i(frame_sync_n_i),
    .load_strobe_n_i(load_strobe_n_i),
    .chain_enable_i(chain_enable_i),
    .clear_n_i(clear_n_i),
    .pins(pins)
  );

  // A bit is taken only on a falling shift clock inside a frame
  assign shift_en_w = pins.shift_fall & ~pins.frame_n; // RQ1
  // New bit enters at the LSB; the oldest leaves the MSB end
  assign nxt_shift_w = {shift_ff[WORD_W-2:0], pins.data}; // RQ1

  // Edge count restarts whenever the frame is idle; it saturates so a long
  // cascade frame does not fire the automatic update a second time
  assign nxt_cnt_w = pins.frame_n ? CNT_ZERO :
                     (shift_en_w && cnt_ff != CNT_SAT) ? cnt_ff + CNT_ONE :
                     cnt_ff;

  // Strobe held low: the sixteenth falling edge of the frame updates
  assign auto_w = shift_en_w & ~pins.load_n & (cnt_ff == CNT_LAST); // RQ4
  // A falling strobe transfers the register as it stands
  assign ext_w = pins.load_fall; // RQ5

  // Clear wins over both updates; the automatic one sees the new bit
  assign nxt_dac_w = ~pins.clear_n ? CLR_DAC : // RQ15
                     auto_w ? dac_bits(nxt_shift_w) : // RQ14
                     ext_w ? dac_bits(shift_ff) : // RQ14
                     dac_ff;

  // Cascade bit only leaves the device while chaining is enabled, so an
  // unchained device keeps its output quiet
  assign nxt_chain_w = pins.chain_en & shift_ff[WORD_W-1]; // RQ16

  // Input shift register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shift_ff <= RST_WORD;
    end else if (shift_en_w) begin
      shift_ff <= nxt_shift_w; // RQ10
    end
  end

  // Frame edge counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= CNT_ZERO;
    end else begin
      cnt_ff <= nxt_cnt_w; // RQ4
    end
  end

  // DAC latch and its update pulse
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dac_ff <= RST_DAC;
      update_ff <= RST_LOW;
    end else begin
      dac_ff <= nxt_dac_w;
      update_ff <= pins.clear_n & (auto_w | ext_w);
    end
  end

  // Cascade output register; one cycle behind the shift register, far
  // inside the shift clock period
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chain_out_ff <= RST_LOW;
    end else begin
      chain_out_ff <= nxt_chain_w; // RQ10
    end
  end

  // Outputs come straight from flip-flops
  assign dac_code_o = dac_ff;
  assign dac_update_o = update_ff;
  assign input_word_o = shift_ff;
  assign chain_out_o = chain_out_ff;

  // Checks on the loader's own behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_shift_takes_bit: assert property ( // RQ1
    shift_en_w |=> (shift_ff[0] == $past(pins.data)) && (shift_ff[WORD_W-1:1] == $past(shift_ff[WORD_W-2:0])))
    else $error("shift register did not take the serial bit");

  a_shift_holds_idle: assert property ( // RQ1
    (pins.frame_n || !pins.shift_fall) |=> $stable(shift_ff))
    else $error("shift register moved outside a falling edge in frame");

  a_auto_sixteenth: assert property ( // RQ4
    (shift_en_w && !pins.load_n && cnt_ff == CNT_LAST && pins.clear_n)
      |=> (dac_ff == $past(nxt_shift_w[DAC_W-1:0])) && update_ff)
    else $error("automatic update missed on sixteenth edge");

  a_ext_transfer: assert property ( // RQ5
    (pins.load_fall && pins.clear_n && !auto_w) |=> (dac_ff == $past(shift_ff[DAC_W-1:0])) && update_ff)
    else $error("falling strobe did not transfer the register");

  a_latch_holds: assert property ( // RQ14
    (!auto_w && !ext_w && pins.clear_n) |=> $stable(dac_ff) && !update_ff)
    else $error("DAC latch changed without an update");

  a_clear_zeros: assert property ( // RQ15
    !pins.clear_n |=> (dac_ff == CLR_DAC) && !update_ff)
    else $error("clear did not force the latch to zero");

  a_chain_follows: assert property ( // RQ16
    pins.chain_en |=> chain_out_ff == $past(shift_ff[WORD_W-1]))
    else $error("chain output does not follow the register MSB");

  a_chain_quiet: assert property ( // RQ10
    !pins.chain_en |=> !chain_out_ff)
    else $error("chain output active while chaining is disabled");

  a_count_bounds: assert property ( // RQ4
    pins.frame_n |=> (cnt_ff == CNT_ZERO))
    else $error("edge count not cleared by idle frame");

  // A saturated count must stay put so one frame gives one automatic update
  a_count_saturates: assert property ( // RQ4
    (!pins.frame_n && cnt_ff == CNT_SAT) |=> (cnt_ff == CNT_SAT))
    else $error("edge count left saturation inside a frame");
endmodule : sdl_word_loader

// file: verilog/sdl_pkg.sv
// Shared constants for the serial DAC word loader
package sdl_pkg;
  // Word geometry
  localparam int WORD_W = 16;            // Input shift register width
  localparam int DAC_W = 12;             // DAC latch width, low bits of the word
  localparam int CNT_W = 5;              // Falling-edge counter width
  // Edge counter constants
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h0F;  // Count before the sixteenth edge
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h10;   // Counter stops here
  // Reset values
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [DAC_W-1:0] RST_DAC = 12'h000;
  localparam logic [DAC_W-1:0] CLR_DAC = 12'h000;  // Value forced by clear
  localparam logic RST_SCLK = 1'b0;      // Shift clock idles low
  localparam logic RST_HIGH = 1'b1;      // Idle level of active-low pins
  localparam logic RST_LOW = 1'b0;
  // Timing of the system clock and the load strobe
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOAD_MIN_NS = 50;       // Least low time of a load strobe pulse
  localparam int LOAD_MIN_CYC = (LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 2;           // Depth of each pin synchroniser
  // Pin positions inside the synchroniser vectors
  localparam int PIN_SCLK = 5;           // Shift clock
  localparam int PIN_DATA = 4;           // Serial data
  localparam int PIN_FRAME = 3;          // Frame sync, active low
  localparam int PIN_LOAD = 2;           // Load strobe, active low
  localparam int PIN_CHAIN = 1;          // Chain enable
  localparam int PIN_CLEAR = 0;          // Clear, active low
endpackage : sdl_pkg

// file: verilog/sdl_pin_if.sv
// Synchronised pin levels and edge pulses between the loader modules
`timescale 1ns/10ps
interface sdl_pin_if;
  logic shift_fall;   // One-cycle pulse: shift clock fell
  logic data;         // Serial data level, aligned with shift_fall
  logic frame_n;      // Frame sync level, active low
  logic load_n;       // Load strobe level, active low
  logic load_fall;    // One-cycle pulse: load strobe fell
  logic chain_en;     // Chain enable level
  logic clear_n;      // Clear level, active low

  // Producer side: the pin synchroniser
  modport src (
    output shift_fall, data, frame_n, load_n, load_fall, chain_en, clear_n
  );
  // Consumer side: the word loader
  modport dst (
    input shift_fall, data, frame_n, load_n, load_fall, chain_en, clear_n
  );
endinterface : sdl_pin_if

// file: verilog/sdl_pin_sync.sv
// Two-stage pin synchronisers and edge detectors for the loader pins
`timescale 1ns/10ps
module sdl_pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Raw pins
  input wire logic shift_clk_i,
  input wire logic serial_in_i,
  input wire logic frame_sync_n_i,
  input wire logic load_strobe_n_i,
  input wire logic chain_enable_i,
  input wire logic clear_n_i,
  // Synchronised view
  sdl_pin_if.src pins
);
  import sdl_pkg::*;

  localparam int NPIN = 6;
  // Pin order in the vectors: sclk, data, frame, load, chain, clear
  localparam logic [NPIN-1:0] RST_VEC = {RST_SCLK, RST_LOW, RST_HIGH, RST_HIGH, RST_LOW, RST_HIGH};

  logic [NPIN-1:0] raw_w;     // Pins gathered
  logic [NPIN-1:0] meta_ff;   // First stage, read only by the second
  logic [NPIN-1:0] sync_ff;   // Second stage, safe to use
  logic sclk_prev_ff;         // Delayed shift clock for edge finding
  logic load_prev_ff;         // Delayed load strobe for edge finding

  assign raw_w = {shift_clk_i, serial_in_i, frame_sync_n_i, load_strobe_n_i, chain_enable_i, clear_n_i};

  // Synchroniser chain; idle levels at reset so no false edge appears
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_ff <= RST_VEC;
      sync_ff <= RST_VEC;
    end else begin
      meta_ff <= raw_w;
      sync_ff <= meta_ff;
    end
  end

  // History taps for the two edge detectors
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sclk_prev_ff <= RST_SCLK;
      load_prev_ff <= RST_HIGH;
    end else begin
      sclk_prev_ff <= sync_ff[PIN_SCLK];
      load_prev_ff <= sync_ff[PIN_LOAD];
    end
  end

  // Edge pulses and levels; data shares the clock's delay so it stays aligned
  assign pins.shift_fall = sclk_prev_ff & ~sync_ff[PIN_SCLK];
  assign pins.data = sync_ff[PIN_DATA];
  assign pins.frame_n = sync_ff[PIN_FRAME];
  assign pins.load_n = sync_ff[PIN_LOAD];
  assign pins.load_fall = load_prev_ff & ~sync_ff[PIN_LOAD];
  assign pins.chain_en = sync_ff[PIN_CHAIN];
  assign pins.clear_n = sync_ff[PIN_CLEAR];
endmodule : sdl_pin_sync

// file: verif/sdl_host_model.sv
// Host serial port model that drives the loader's shift clock, data, frame sync and load strobe pins
`timescale 1ns/10ps
module sdl_host_model (
  // Clock
  input wire logic clk_i,
  // Host pins
  output logic shift_clk_o,
  output logic serial_in_o,
  output logic frame_sync_n_o,
  output logic load_strobe_n_o
);
  // Idle levels: clock low, frame and strobe high
  initial begin
    shift_clk_o = 1'b0;
    serial_in_o = 1'b0;
    frame_sync_n_o = 1'b1;
    load_strobe_n_o = 1'b1;
  end
  // Wait n system clocks, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // Frame goes low well before the first data clock
  task automatic frame_open();
    frame_sync_n_o = 1'b0;
    tick(4);
  endtask : frame_open
  // Released data line shows the inverse so a stale bit cannot pass
  task automatic frame_close();
    frame_sync_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
    tick(4);
  endtask : frame_close
  // MSB first; data changes on the rise and is valid at the fall
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      shift_clk_o = 1'b1;
      serial_in_o = b[i];
      tick(5);
      shift_clk_o = 1'b0;
      tick(5);
    end
  endtask : send_byte
  // One word as two bytes, frame held low between them
  task automatic send_word(input logic [15:0] w);
    frame_open();
    send_byte(w[15:8]);
    send_byte(w[7:0]);
    frame_close();
  endtask : send_word
  // Strobe held at a level (low selects automatic update)
  task automatic set_strobe(input logic lvl);
    load_strobe_n_o = lvl;
    tick(6);
  endtask : set_strobe
  // Low for 7 clocks, 56 ns, after the frame has risen
  task automatic pulse_strobe();
    load_strobe_n_o = 1'b0;
    tick(7);
    load_strobe_n_o = 1'b1;
    tick(5);
  endtask : pulse_strobe
endmodule : sdl_host_model

// file: verif/tb_top.sv
// Self-checking bench for the serial word loader
`timescale 1ns/10ps
module tb_top;
  logic clk_i;
  logic srst_i;
  logic sclk, sdata, frame_n, strobe_n;
  logic chain_enable, clear_n;
  logic [11:0] dac_code;
  logic dac_update;
  logic [15:0] input_word;
  logic chain_out;
  logic [15:0] upd_cnt; // Latch updates seen
  logic [15:0] base;
  int error_cnt;
  int total_checks;
  // System clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  sdl_host_model u_sdl_host_model (.clk_i(clk_i), .shift_clk_o(sclk), .serial_in_o(sdata),
    .frame_sync_n_o(frame_n), .load_strobe_n_o(strobe_n));
  sdl_word_loader u_sdl_word_loader (.clk_i(clk_i), .srst_i(srst_i), .shift_clk_i(sclk),
    .serial_in_i(sdata), .frame_sync_n_i(frame_n), .load_strobe_n_i(strobe_n),
    .chain_enable_i(chain_enable), .clear_n_i(clear_n), .dac_code_o(dac_code),
    .dac_update_o(dac_update), .input_word_o(input_word), .chain_out_o(chain_out));
  // Count update pulses
  initial upd_cnt = 16'h0000;
  always @(posedge clk_i) begin
    if (dac_update === 1'b1) begin
      upd_cnt <= upd_cnt + 16'h0001;
    end
  end
  // Compare tasks, one per result width
  task automatic chk12(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk12
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  // Verdict and end of run
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // Watchdog: the tests need about 11 us
  initial begin
    #60000;
    error_cnt++;
    close_out();
  end
  // Main sequence
  initial begin
    error_cnt = 0;
    total_checks = 0;
    srst_i = 1'b1;
    chain_enable = 1'b1;
    clear_n = 1'b1;
    u_sdl_host_model.tick(16);
    srst_i = 1'b0;
    u_sdl_host_model.tick(4);
    // Automatic update with strobe tied low
    u_sdl_host_model.set_strobe(1'b0);
    base = upd_cnt;
    u_sdl_host_model.send_word(16'hA5C3);
    chk16(input_word, 16'hA5C3);
    chk12(dac_code, 12'h5C3);
    chk1(chain_out, 1'b1);
    // Two bytes with a gap, then surplus clocks in the same frame
    u_sdl_host_model.frame_open();
    u_sdl_host_model.send_byte(8'h3F);
    chk12(dac_code, 12'h5C3);
    u_sdl_host_model.tick(24);
    u_sdl_host_model.send_byte(8'h1E);
    chk12(dac_code, 12'hF1E);
    u_sdl_host_model.send_byte(8'hFF);
    u_sdl_host_model.frame_close();
    chk16(input_word, 16'h1EFF);
    chk12(dac_code, 12'hF1E);
    chk16(upd_cnt - base, 16'h0002);
    // External strobe: no update until its falling edge
    u_sdl_host_model.set_strobe(1'b1);
    u_sdl_host_model.send_word(16'h0ABC);
    chk12(dac_code, 12'hF1E);
    u_sdl_host_model.pulse_strobe();
    chk12(dac_code, 12'hABC);
    chk16(upd_cnt - base, 16'h0003);
    // Chain output gated by chain enable, then a two-word ripple
    chain_enable = 1'b0;
    u_sdl_host_model.send_word(16'h8001);
    chk1(chain_out, 1'b0);
    chain_enable = 1'b1;
    u_sdl_host_model.tick(4);
    chk1(chain_out, 1'b1);
    u_sdl_host_model.frame_open();
    u_sdl_host_model.send_byte(8'hC0);
    u_sdl_host_model.send_byte(8'h01);
    u_sdl_host_model.send_byte(8'h7F);
    chk1(chain_out, 1'b0);
    u_sdl_host_model.send_byte(8'hFE);
    u_sdl_host_model.frame_close();
    chk16(input_word, 16'h7FFE);
    chk12(dac_code, 12'hABC);
    // Clear forces the latch, shift register untouched
    clear_n = 1'b0;
    u_sdl_host_model.tick(5);
    chk12(dac_code, 12'h000);
    chk16(input_word, 16'h7FFE);
    clear_n = 1'b1;
    u_sdl_host_model.tick(4);
    chk12(dac_code, 12'h000);
    chk16(upd_cnt - base, 16'h0003);
    // Reset in mid-run clears the register, then an external update works again
    srst_i = 1'b1;
    u_sdl_host_model.tick(4);
    srst_i = 1'b0;
    u_sdl_host_model.tick(4);
    chk16(input_word, 16'h0000);
    u_sdl_host_model.send_word(16'h5A5A);
    chk12(dac_code, 12'h000);
    u_sdl_host_model.pulse_strobe();
    chk12(dac_code, 12'hA5A);
    chk16(upd_cnt - base, 16'h0004);
    close_out();
  end
endmodule : tb_top
